// file: design/bpel_event_logic.sv
`timescale 1ns/1ps
// How it works
// RULE1 - startup-on with flag set when start conditions met and flag set
// RULE2 - startup-on with flag reset when start conditions met and flag clear
// RULE3 - no-air setup only if check off, no air input, start-off cancel, internal
// RULE4 - any of those four differing means startup has air setup
// RULE5 - startup-off event when start conditions stop being met, or are not met in the first cycle after reset
// RULE6 - lockout on lockout-class error; cancel event only on proper reset
// RULE7 - air switch on/off events from inputs assigned the air function
// RULE8 - purge-count-start on/off events from inputs with that function
// RULE9 - prepurge ok when all condition inputs on and no fire position on
// RULE10 - prepurge passed after normal time, or trial time in trial mode
// RULE11 - blower on/off events from the selected blower sync source
// RULE12 - air-off confirmation flag cleared at power-up
// RULE13 - flag-set action marks confirmation done; flag-reset marks not done
// RULE14 - prepurge initialization forces the timing counter to zero
// RULE15 - blower-off confirmation clears the flag only if blower is already off at that action
// RULE16 - blower-off cancel mode: rise of interlock-open error with air switch off clears the set flag
// RULE17 - counter steps on each tick in prepurge up to the setting; passes at the setting
module bpel_event_logic (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // field pins
  input wire logic [bpel_pkg::NUM_IN-1:0] FIELD_IN,
  // configuration
  input wire bpel_pkg::bpel_cfg_t CFG,
  input wire logic TRIAL_MODE,
  // partner and sequencer
  input wire logic START_COND,
  input wire logic PARTNER_BLOWER,
  input wire logic INTERNAL_BLOWER,
  input wire logic ERR_LOCKOUT,
  input wire logic ERR_CLEARED_PROPER,
  input wire logic INTERLOCK_INPUT_OPEN_ERROR,
  // actions
  input wire logic ACT_FLAG_SET,
  input wire logic ACT_FLAG_RESET,
  input wire logic ACT_PP_INIT,
  input wire logic ACT_BLOWER_OFF_CONFIRM,
  input wire logic PURGE_RUN,
  // results
  output bpel_pkg::bpel_evt_t EVT,
  output logic AIR_OFF_CONFIRMED,
  output logic [bpel_pkg::TIME_W-1:0] PP_COUNT
);

  // ==========================================================
  // functions
  function automatic logic [bpel_pkg::NUM_IN-1:0] fn_mask(
    input bpel_pkg::bpel_cfg_t cfg,
    input bpel_pkg::bpel_fn_t fn
  );
    logic [bpel_pkg::NUM_IN-1:0] m;
    m = '0;
    for (int i = 0; i < bpel_pkg::NUM_IN; i++)
    begin
      m[i] = (cfg.in_fn[i] == fn);
    end
    return m;
  endfunction

  // ==========================================================
  // input synchronisation
  logic [bpel_pkg::NUM_IN-1:0] pin_s;

  bpel_sync #(
    .W(bpel_pkg::NUM_IN)
  ) u_sync (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .din(FIELD_IN),
    .dout(pin_s)
  );

  // ==========================================================
  // decoded levels
  logic [bpel_pkg::NUM_IN-1:0] air_m;
  logic [bpel_pkg::NUM_IN-1:0] purge_m;
  logic [bpel_pkg::NUM_IN-1:0] cond_m;
  logic air_on;
  logic purge_on;
  logic pp_ok;
  logic blower_lvl;
  logic no_air_setup;
  logic [bpel_pkg::TIME_W-1:0] pp_limit;

  always_comb
  begin
    air_m = fn_mask(CFG, bpel_pkg::BPEL_FN_AIR_SW);
    purge_m = fn_mask(CFG, bpel_pkg::BPEL_FN_PURGE_START);
    cond_m = fn_mask(CFG, bpel_pkg::BPEL_FN_PP_COND)
      | fn_mask(CFG, bpel_pkg::BPEL_FN_IL_PP_COND);
    air_on = (air_m != '0) && ((pin_s & air_m) == air_m); // [RULE7]
    purge_on = (purge_m != '0)
      && ((pin_s & purge_m) == purge_m); // [RULE8]
    pp_ok = ((pin_s & cond_m) == cond_m)
      && !pin_s[CFG.high_fire_sel]
      && !pin_s[CFG.low_fire_sel]; // [RULE9]
    case (CFG.blower_src) // [RULE11]
      bpel_pkg::BPEL_BS_INTERNAL: blower_lvl = INTERNAL_BLOWER;
      bpel_pkg::BPEL_BS_INPUT: blower_lvl = pin_s[CFG.blower_in_sel];
      bpel_pkg::BPEL_BS_PARTNER: blower_lvl = PARTNER_BLOWER;
      default: blower_lvl = INTERNAL_BLOWER;
    endcase
    no_air_setup = !CFG.air_check_en && (air_m == '0)
      && (CFG.cancel_cond == bpel_pkg::BPEL_CC_START_OFF)
      && (CFG.blower_src == bpel_pkg::BPEL_BS_INTERNAL); // [RULE3]
    pp_limit = TRIAL_MODE ? CFG.pp_time_trial : CFG.pp_time; // [RULE10]
  end

  // ==========================================================
  // previous levels for edge events
  logic start_q;
  logic air_q;
  logic purge_q;
  logic pp_q;
  logic blower_q;
  logic lock_q;
  logic clr_q;
  logic primed_q;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      start_q <= 1'b0;
      air_q <= 1'b0;
      purge_q <= 1'b0;
      pp_q <= 1'b0;
      blower_q <= 1'b0;
      lock_q <= 1'b0;
      clr_q <= 1'b0;
      primed_q <= 1'b0;
    end
    else if (CE)
    begin
      start_q <= START_COND;
      air_q <= air_on;
      purge_q <= purge_on;
      pp_q <= pp_ok;
      blower_q <= blower_lvl;
      lock_q <= ERR_LOCKOUT;
      clr_q <= ERR_CLEARED_PROPER;
      primed_q <= 1'b1;
    end
  end

  // ==========================================================
  // air pressure off confirmation flag
  logic flag_q;
  logic flag_d;
  logic ilo_q;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ilo_q <= 1'b0;
    end
    else if (CE)
    begin
      ilo_q <= INTERLOCK_INPUT_OPEN_ERROR;
    end
  end

  always_comb
  begin
    flag_d = flag_q;
    if (ACT_FLAG_RESET)
    begin
      flag_d = 1'b0; // [RULE13]
    end
    if (ACT_BLOWER_OFF_CONFIRM && !blower_lvl)
    begin
      flag_d = 1'b0; // [RULE15]
    end
    if ((CFG.cancel_cond == bpel_pkg::BPEL_CC_BLOWER_OFF)
      && INTERLOCK_INPUT_OPEN_ERROR && !ilo_q && !air_on)
    begin
      flag_d = 1'b0; // [RULE16]
    end
    if (ACT_FLAG_SET)
    begin
      flag_d = 1'b1; // [RULE13]
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      flag_q <= bpel_pkg::FLAG_RST; // [RULE12]
    end
    else if (CE)
    begin
      flag_q <= flag_d;
    end
  end

  assign AIR_OFF_CONFIRMED = flag_q;

  // ==========================================================
  // prepurge time base and counter
  logic [31:0] tick_q;
  logic tick;
  logic [bpel_pkg::TIME_W-1:0] pp_q_cnt;
  logic passed_q;

  assign tick = (tick_q == 32'(bpel_pkg::TICK_CYC - 1));

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      tick_q <= '0;
    end
    else if (CE)
    begin
      if (tick || ACT_PP_INIT || !PURGE_RUN)
      begin
        tick_q <= '0;
      end
      else
      begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pp_q_cnt <= bpel_pkg::PP_CNT_RST;
      passed_q <= 1'b0;
    end
    else if (CE)
    begin
      if (ACT_PP_INIT)
      begin
        pp_q_cnt <= bpel_pkg::PP_CNT_RST; // [RULE14]
        passed_q <= 1'b0;
      end
      else if (PURGE_RUN && tick && (pp_q_cnt < pp_limit))
      begin
        pp_q_cnt <= pp_q_cnt + 16'h1; // [RULE17]
      end
      passed_q <= !ACT_PP_INIT && PURGE_RUN
        && (pp_q_cnt >= pp_limit); // [RULE17]
    end
  end

  assign PP_COUNT = pp_q_cnt;

  // ==========================================================
  // registered event pulses
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      EVT <= '0;
    end
    else if (CE)
    begin
      EVT.startup_on_set <= START_COND && !start_q && flag_q; // [RULE1]
      EVT.startup_on_reset <= START_COND && !start_q && !flag_q; // [RULE2]
      EVT.startup_without_air <= START_COND && !start_q
        && no_air_setup; // [RULE3]
      EVT.startup_with_air <= START_COND && !start_q
        && !no_air_setup; // [RULE4]
      EVT.startup_off <= !START_COND && (start_q || !primed_q); // [RULE5]
      EVT.lockout <= ERR_LOCKOUT && !lock_q; // [RULE6]
      EVT.err_cancel <= ERR_CLEARED_PROPER && !clr_q; // [RULE6]
      EVT.air_sw_on <= air_on && !air_q; // [RULE7]
      EVT.air_sw_off <= !air_on && air_q; // [RULE7]
      EVT.purge_start_on <= purge_on && !purge_q; // [RULE8]
      EVT.purge_start_off <= !purge_on && purge_q; // [RULE8]
      EVT.pp_cond_ok <= pp_ok && !pp_q; // [RULE9]
      EVT.pp_cond_ng <= !pp_ok && (pp_q || !primed_q); // [RULE9]
      EVT.pp_time_passed <= passed_q == 1'b0 && !ACT_PP_INIT && PURGE_RUN
        && (pp_q_cnt >= pp_limit); // [RULE10]
      EVT.blower_on <= blower_lvl && !blower_q; // [RULE11]
      EVT.blower_off <= !blower_lvl && blower_q; // [RULE11]
    end
  end

endmodule // bpel_event_logic

// file: design/bpel_sync.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage pin synchroniser with agreement filter
module bpel_sync #(
  parameter int W = 4
) (
  // clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // bpel_sync

// file: pkg/bpel_pkg.sv
package bpel_pkg;

  // ==========================================================
  // widths and counts
  localparam int NUM_IN = 4;
  localparam int TIME_W = 16;
  // prepurge time base: one tick per 100 ms
  localparam int TICK_MS = 100;
  localparam int CLK_KHZ = 25000;
  localparam int TICK_CYC = TICK_MS * CLK_KHZ;
  localparam logic [TIME_W-1:0] PP_CNT_RST = 16'h0000;
  localparam logic FLAG_RST = 1'b0;

  // ==========================================================
  // input function codes
  typedef enum logic [2:0] {
    BPEL_FN_NONE = 3'h0,
    BPEL_FN_AIR_SW = 3'h1,
    BPEL_FN_PURGE_START = 3'h2,
    BPEL_FN_PP_COND = 3'h3,
    BPEL_FN_IL_PP_COND = 3'h4
  } bpel_fn_t;

  // check cancel condition
  typedef enum logic [1:0] {
    BPEL_CC_START_OFF = 2'h0,
    BPEL_CC_BLOWER_OFF = 2'h1,
    BPEL_CC_OTHER = 2'h2
  } bpel_cancel_t;

  // blower sync source
  typedef enum logic [1:0] {
    BPEL_BS_INTERNAL = 2'h0,
    BPEL_BS_INPUT = 2'h1,
    BPEL_BS_PARTNER = 2'h2
  } bpel_bsrc_t;

  typedef struct packed {
    bpel_fn_t [NUM_IN-1:0] in_fn;
    logic air_check_en;
    bpel_cancel_t cancel_cond;
    bpel_bsrc_t blower_src;
    logic [1:0] blower_in_sel;
    logic [1:0] high_fire_sel;
    logic [1:0] low_fire_sel;
    logic [TIME_W-1:0] pp_time;
    logic [TIME_W-1:0] pp_time_trial;
  } bpel_cfg_t;

  typedef struct packed {
    logic startup_on_set;
    logic startup_on_reset;
    logic startup_with_air;
    logic startup_without_air;
    logic startup_off;
    logic lockout;
    logic err_cancel;
    logic air_sw_on;
    logic air_sw_off;
    logic purge_start_on;
    logic purge_start_off;
    logic pp_cond_ok;
    logic pp_cond_ng;
    logic pp_time_passed;
    logic blower_on;
    logic blower_off;
  } bpel_evt_t;

endpackage

// file: verification/bpel_event_logic_sva.sv
`timescale 1ns/1ps
// ==============================
// event logic checks
module bpel_event_logic_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // stimulus
  input wire logic START_COND,
  input wire logic INTERNAL_BLOWER,
  input wire logic ERR_LOCKOUT,
  input wire logic ERR_CLEARED_PROPER,
  input wire logic ACT_FLAG_SET,
  input wire logic ACT_FLAG_RESET,
  input wire logic ACT_PP_INIT,
  input wire logic PURGE_RUN,
  input wire logic TRIAL_MODE,
  input wire bpel_pkg::bpel_cfg_t CFG,
  // results
  input wire bpel_pkg::bpel_evt_t EVT,
  input wire logic AIR_OFF_CONFIRMED,
  input wire logic [bpel_pkg::TIME_W-1:0] PP_COUNT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic no_air;
  logic [bpel_pkg::TIME_W-1:0] lim_q;

  always_comb
  begin
    no_air = !CFG.air_check_en;
    if (CFG.cancel_cond != bpel_pkg::BPEL_CC_START_OFF)
      no_air = 1'b0;
    if (CFG.blower_src != bpel_pkg::BPEL_BS_INTERNAL)
      no_air = 1'b0;
    for (int i = 0; i < bpel_pkg::NUM_IN; i++)
      if (CFG.in_fn[i] == bpel_pkg::BPEL_FN_AIR_SW)
        no_air = 1'b0;
  end

  always_ff @(posedge CLK)
    lim_q <= TRIAL_MODE ? CFG.pp_time_trial : CFG.pp_time;

  sequence s_rise;
    $rose(START_COND) && !ACT_FLAG_SET && !ACT_FLAG_RESET;
  endsequence

  a_start_flag_set: assert property (s_rise ##0 AIR_OFF_CONFIRMED
    |=> EVT.startup_on_set) else $error("startup on set missing");
  a_start_flag_clr: assert property (s_rise ##0 !AIR_OFF_CONFIRMED
    |=> EVT.startup_on_reset) else $error("startup on reset missing");
  a_air_class: assert property (EVT.startup_on_set || EVT.startup_on_reset
    |-> EVT.startup_without_air == no_air && EVT.startup_with_air == !no_air)
    else $error("air setup class wrong");
  a_start_off: assert property ($fell(START_COND) |=> EVT.startup_off)
    else $error("startup off missing");
  a_lockout_evt: assert property ($rose(ERR_LOCKOUT) |=> EVT.lockout)
    else $error("lockout missing");
  a_cancel_cause: assert property (EVT.err_cancel
    |-> $past(ERR_CLEARED_PROPER)) else $error("cancel without reset");
  a_flag_set: assert property (ACT_FLAG_SET |=> AIR_OFF_CONFIRMED)
    else $error("flag not set");
  a_flag_clear: assert property (ACT_FLAG_RESET && !ACT_FLAG_SET
    |=> !AIR_OFF_CONFIRMED) else $error("flag not cleared");
  a_pp_init: assert property (ACT_PP_INIT |=> PP_COUNT == 16'h0000)
    else $error("count not cleared");
  a_pp_passed: assert property (EVT.pp_time_passed
    |-> $past(PURGE_RUN) && $past(PP_COUNT) >= lim_q)
    else $error("prepurge passed early");
  a_blower_int: assert property (CFG.blower_src == 2'h0
    && $rose(INTERNAL_BLOWER) |=> EVT.blower_on) else $error("no blower on");
endmodule // bpel_event_logic_sva

bind bpel_event_logic bpel_event_logic_sva bpel_event_logic_sva_i (
  .CLK(CLK), .RESET(RESET), .START_COND(START_COND),
  .INTERNAL_BLOWER(INTERNAL_BLOWER), .ERR_LOCKOUT(ERR_LOCKOUT),
  .ERR_CLEARED_PROPER(ERR_CLEARED_PROPER), .ACT_FLAG_SET(ACT_FLAG_SET),
  .ACT_FLAG_RESET(ACT_FLAG_RESET), .ACT_PP_INIT(ACT_PP_INIT),
  .PURGE_RUN(PURGE_RUN), .TRIAL_MODE(TRIAL_MODE), .CFG(CFG), .EVT(EVT),
  .AIR_OFF_CONFIRMED(AIR_OFF_CONFIRMED), .PP_COUNT(PP_COUNT));

// file: verification/bpel_field_model.sv
`timescale 1ns/1ps
// ==============================
// field contacts, switched off the clock
module bpel_field_model (
  // request
  input wire logic [bpel_pkg::NUM_IN-1:0] want,
  // pins
  output logic [bpel_pkg::NUM_IN-1:0] pins
);
  initial
    pins = '0;
  always @(want)
    pins <= #13 want;
endmodule // bpel_field_model

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst, trial, start, elock, eok, ilo, prun, flag;
  logic [3:0] act, w, pins;
  logic [2:0] bs;
  logic [15:0] cnt, seen;
  bpel_pkg::bpel_cfg_t cfg, base, c;
  bpel_pkg::bpel_evt_t evt, ev_s;
  int n_errors, num_checks;

  bpel_field_model bpel_field_model_i (.want(w | {2'h0, bs[1], 1'b0}),
    .pins(pins));
  bpel_event_logic bpel_event_logic_i (.CLK(clk), .RESET(rst), .CE(1'b1),
    .FIELD_IN(pins), .CFG(cfg), .TRIAL_MODE(trial), .START_COND(start),
    .PARTNER_BLOWER(bs[2]), .INTERNAL_BLOWER(bs[0]), .ERR_LOCKOUT(elock),
    .ERR_CLEARED_PROPER(eok), .INTERLOCK_INPUT_OPEN_ERROR(ilo),
    .ACT_FLAG_SET(act[0]), .ACT_FLAG_RESET(act[1]), .ACT_PP_INIT(act[2]),
    .ACT_BLOWER_OFF_CONFIRM(act[3]), .PURGE_RUN(prun), .EVT(evt),
    .AIR_OFF_CONFIRMED(flag), .PP_COUNT(cnt));

  // ==============================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input logic [15:0] m);
    seen = 16'h0000;
    for (int i = 0; i < 12 && seen === 16'h0000; i++)
    begin
      @(posedge clk);
      #1;
      seen = evt & m;
      ev_s = evt;
    end
  endtask

  task automatic setc(input bpel_pkg::bpel_cfg_t v);
    @(posedge clk) cfg <= v;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk) act <= m;
    @(posedge clk) act <= 4'h0;
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==============================
  // scenarios
  task automatic t_start;
    for (int k = 0; k < 10; k++)
    begin
      c = base;
      case (k / 2)
        1: c.air_check_en = 1'b1;
        2: c.in_fn[3] = bpel_pkg::BPEL_FN_AIR_SW;
        3: c.cancel_cond = bpel_pkg::BPEL_CC_OTHER;
        4: c.blower_src = bpel_pkg::BPEL_BS_PARTNER;
        default: ;
      endcase
      setc(c);
      pulse(k[0] ? 4'h1 : 4'h2);
      chk(16'(flag), 16'(k[0]));
      @(posedge clk) start <= 1'b1;
      wt(16'hc000);
      chk(seen, k[0] ? 16'h8000 : 16'h4000);
      chk(16'({ev_s.startup_with_air, ev_s.startup_without_air}),
        k < 2 ? 16'h0001 : 16'h0002);
      @(posedge clk) start <= 1'b0;
      wt(16'h0800);
      chk(seen, 16'h0800);
    end
    $display("done startup");
  endtask

  task automatic t_field;
    logic [3:0] tw [8] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'hc, 4'he, 4'hc, 4'h4};
    logic [15:0] tm [8] = '{16'h0100, 16'h0080, 16'h0040, 16'h0020,
      16'h0010, 16'h0008, 16'h0010, 16'h0008};
    c = base;
    c.in_fn[0] = bpel_pkg::BPEL_FN_AIR_SW;
    c.in_fn[1] = bpel_pkg::BPEL_FN_PURGE_START;
    setc(c);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        c = base;
        c.in_fn[2] = bpel_pkg::BPEL_FN_PP_COND;
        c.in_fn[3] = bpel_pkg::BPEL_FN_IL_PP_COND;
        c.low_fire_sel = 2'h1;
        setc(c);
      end
      @(posedge clk) w <= tw[i];
      wt(tm[i]);
      chk(seen, tm[i]);
    end
    @(posedge clk) w <= 4'h0;
    $display("done field");
  endtask

  task automatic t_lock;
    @(posedge clk) elock <= 1'b1;
    wt(16'h0400);
    chk(seen, 16'h0400);
    @(posedge clk) eok <= 1'b1;
    elock <= 1'b0;
    wt(16'h0200);
    chk(seen, 16'h0200);
    @(posedge clk) eok <= 1'b0;
    $display("done lockout");
  endtask

  task automatic t_purge;
    c = base;
    c.pp_time_trial = 16'h0005;
    setc(c);
    @(posedge clk) trial <= 1'b1;
    pulse(4'h4);
    chk(cnt, 16'h0000);
    @(posedge clk) prun <= 1'b1;
    wt(16'h0004);
    chk(seen, 16'h0000);
    @(posedge clk) trial <= 1'b0;
    wt(16'h0004);
    chk(seen, 16'h0004);
    @(posedge clk) prun <= 1'b0;
    $display("done prepurge");
  endtask

  task automatic t_blow;
    for (int s = 0; s < 3; s++)
    begin
      c = base;
      c.blower_src = bpel_pkg::bpel_bsrc_t'(s);
      c.blower_in_sel = 2'h1;
      setc(c);
      @(posedge clk) bs <= ~(3'h1 << s);
      wt(16'h0002);
      chk(seen, 16'h0000);
      @(posedge clk) bs <= 3'h7;
      wt(16'h0002);
      chk(seen, 16'h0002);
      @(posedge clk) bs <= 3'h0;
      wt(16'h0001);
      chk(seen, 16'h0001);
      repeat (8) @(posedge clk);
    end
    $display("done blower");
  endtask

  task automatic t_flag;
    setc(base);
    @(posedge clk) bs <= 3'h1;
    pulse(4'h1);
    pulse(4'h8);
    chk(16'(flag), 16'h0001);
    @(posedge clk) bs <= 3'h0;
    pulse(4'h8);
    chk(16'(flag), 16'h0000);
    c = base;
    c.cancel_cond = bpel_pkg::BPEL_CC_BLOWER_OFF;
    c.in_fn[0] = bpel_pkg::BPEL_FN_AIR_SW;
    setc(c);
    pulse(4'h1);
    @(posedge clk) ilo <= 1'b1;
    for (int i = 0; i < 8 && flag; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(16'(flag), 16'h0000);
    @(posedge clk) ilo <= 1'b0;
    $display("done flag");
  endtask

  // ==============================
  // run
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    {rst, trial, start, elock, eok, ilo, prun} = 7'h40;
    {act, w, bs} = 11'h000;
    base = '0;
    cfg = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(flag), 16'h0000);
    t_start();
    t_field();
    t_lock();
    t_purge();
    t_blow();
    t_flag();
    summarize();
  end
endmodule // tb
